// ==== bench/hvic_die_model.sv ====
// behavioural high-voltage die on the three-wire link (clock, data in, data out)
// assumes the link clock stands low between frames
module hvic_die_model (
    input wire logic clk_i,
    input wire logic ser_clk_i,
    input wire logic ser_mosi_i,
    input wire logic busy_i,
    output logic ser_miso_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] frame = 16'h0;
    initial ser_miso_o = 1'b0;
    // command then data byte, msb first; taken on the falling edge because data moves on the rising one
    always @(negedge ser_clk_i) frame <= {frame[14:0], ser_mosi_i};
    // toggles outside frames so a stale level never passes
    always @(posedge clk_i) ser_miso_o <= busy_i ? frame[7] : ~ser_miso_o;
endmodule : hvic_die_model

// ==== bench/hvic_top_asserts.sv ====
// checker for the indirect config block, bound to hvic_top
// assumes one core clock and a synchronous active-high reset
`include "hvic_cfg.svh"
module hvic_top_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire hvic_pkg::hvic_bus_t bus_i,
    input wire logic [31:0] rdata_o,
    input wire logic ser_clk_o,
    input wire logic busy_o,
    input wire hvic_pkg::hvic_ctrl_t ctrl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // command strobe taken only while idle
    sequence s_cmd;
        bus_i.wr && bus_i.addr == `HVIC_ADDR_COMMAND && !busy_o;
    endsequence
    sequence s_high_half;
        ser_clk_o [*4] ##1 !ser_clk_o;
    endsequence
    sequence s_idle;
        !busy_o ##1 !busy_o;
    endsequence
    property p_busy_start;
        s_cmd |=> busy_o;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy missing after command");
    property p_busy_bound;
        $rose(busy_o) |-> ##[1:260] !busy_o;
    endproperty
    a_busy_bound: assert property (p_busy_bound) else $error("transfer too long");
    property p_link_half;
        $rose(ser_clk_o) |-> s_high_half;
    endproperty
    a_link_half: assert property (p_link_half) else $error("link half period wrong");
    property p_link_idle;
        s_idle |-> !ser_clk_o;
    endproperty
    a_link_idle: assert property (p_link_idle) else $error("link clock runs while idle");
    property p_rd_quiet;
        !bus_i.rd |=> rdata_o == 32'h0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data without strobe");
    property p_pullup;
        !$past(rst_i) |-> ctrl_o.lin_pullup_en != ctrl_o.bit_serial_device_mode;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up and bit-serial mode clash");
    property p_lin;
        ctrl_o.lin_fast == &ctrl_o.lin_mode && ctrl_o.lin_driver_en == ctrl_o.lin_mode[1];
    endproperty
    a_lin: assert property (p_lin) else $error("driver mode decode wrong");
    property p_wake_shut;
        ctrl_o.thermal_shutdown_en |-> !ctrl_o.wake_pin_drive;
    endproperty
    a_wake_shut: assert property (p_wake_shut) else $error("wake driven during shutdown");
    property p_irq;
        ctrl_o.supply_irq_en |-> ctrl_o.supply_monitor_en;
    endproperty
    a_irq: assert property (p_irq) else $error("supply irq without monitor");
endmodule : hvic_top_asserts
bind hvic_top hvic_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .ser_clk_o(ser_clk_o), .busy_o(busy_o), .ctrl_o(ctrl_o));

// ==== bench/test_hvic_indirect_config_regs.sv ====
// self-checking bench for hvic_top with a die link model
// assumes design files and the checker compile first
`include "hvic_cfg.svh"
module test_hv_indirect_config_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import hvic_pkg::*;
    logic clk_i = 0, rst_i = 1, ser_data_i, ser_clk_o, ser_data_o, busy_o, therm = 0, irq_en = 0;
    logic [7:0] sta = 0, mon = 0, b;
    logic [31:0] d, rdata;
    hvic_bus_t bus = '0;
    hvic_ctrl_t ctrl;
    int err_total = 0, checked = 0;
    hvic_top dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata), .supply_irq_line_en_i(irq_en),
        .hv_status_reg_i(sta), .hv_monitor_reg_i(mon), .thermal_event_i(therm), .ser_data_i(ser_data_i),
        .ser_clk_o(ser_clk_o), .ser_data_o(ser_data_o), .busy_o(busy_o), .ctrl_o(ctrl));
    hvic_die_model die (.clk_i(clk_i), .ser_clk_i(ser_clk_o), .ser_mosi_i(ser_data_o), .busy_i(busy_o),
        .ser_miso_o(ser_data_i));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task complete_run;
        if (err_total == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    task check(input logic [11:0] seen, input logic [11:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task wr(input logic [31:0] a, input logic [31:0] v);
        @(negedge clk_i);
        bus.wr = 1;
        bus.addr = a;
        bus.wdata = v;
        @(negedge clk_i);
        bus.wr = 0;
    endtask : wr
    task rd(input logic [31:0] a);
        @(negedge clk_i);
        bus.rd = 1;
        bus.addr = a;
        @(negedge clk_i);
        d = rdata;
        bus.rd = 0;
    endtask : rd
    // software waits for busy clear before the next command
    task cmd(input logic [7:0] c, input logic [2:0] st);
        int n;
        wr(`HVIC_ADDR_COMMAND, {24'h0, c});
        n = 0;
        do begin
            rd(`HVIC_ADDR_COMMAND);
            n++;
        end while (d[0] !== 1'b0 && n < 400);
        if (n >= 400) begin
            err_total++;
            complete_run();
        end
        check({9'h0, d[2:0]}, {9'h0, st});
    endtask : cmd
    task readback(input logic [7:0] c, input logic [11:0] exp);
        cmd(c, 3'b010);
        rd(`HVIC_ADDR_DATA);
        check(d[11:0], exp);
    endtask : readback
    function automatic logic [11:0] exp_ctrl(input logic [7:0] v, input logic t, input logic ie);
        logic shut;
        shut = t & ~v[7];
        return {shut, v[6], ~v[5], v[5], v[4] & ~shut, v[3], v[3] & ie, v[2], v[1:0], &v[1:0], v[1]};
    endfunction : exp_ctrl
    // reset values, then random and corner bytes through every command
    initial begin
        void'($urandom(43847));
        repeat (2) @(negedge clk_i);
        rst_i = 0;
        readback(`HVIC_CMD_RD_CFG_A, 12'h000);
        readback(`HVIC_CMD_RD_CFG_B, 12'h100);
        for (int i = 0; i < 8; i++) begin
            b = (i == 0) ? 8'hff : (i == 1) ? 8'h20 : 8'($urandom);
            therm = 1'($urandom);
            irq_en = 1'($urandom);
            sta = 8'($urandom);
            mon = 8'($urandom);
            wr(`HVIC_ADDR_DATA, {20'h0, 4'hf, b});
            // tag nibble must keep the last read command, not the written ones
            rd(`HVIC_ADDR_DATA);
            check(d[11:0], {(i == 0) ? 4'h1 : 4'h3, b});
            cmd(`HVIC_CMD_WR_CFG_A, 3'b100);
            // the die saw the command byte, then the staging byte
            check({4'h0, die.frame[15:8]}, {4'h0, `HVIC_CMD_WR_CFG_A});
            check({4'h0, die.frame[7:0]}, {4'h0, b});
            check(ctrl, exp_ctrl(b, therm, irq_en));
            readback(`HVIC_CMD_RD_CFG_A, {4'h0, b});
            wr(`HVIC_ADDR_DATA, {24'h0, ~b});
            cmd(`HVIC_CMD_WR_CFG_B, 3'b100);
            readback(`HVIC_CMD_RD_CFG_B, {4'h1, ~b});
            readback(`HVIC_CMD_RD_STATUS, {4'h2, sta});
            readback(`HVIC_CMD_RD_MONITOR, {4'h3, mon & {4'hf, b[2], 3'h7}});
        end
        // unknown code fails and changes nothing; a command while busy is dropped
        cmd(8'h05, 3'b000);
        wr(`HVIC_ADDR_DATA, 32'h5a);
        wr(`HVIC_ADDR_COMMAND, 32'h08);
        cmd(`HVIC_CMD_WR_CFG_B, 3'b100);
        // the dropped command never reached the link
        check({4'h0, die.frame[15:8]}, {4'h0, `HVIC_CMD_WR_CFG_A});
        readback(`HVIC_CMD_RD_CFG_A, 12'h05a);
        readback(`HVIC_CMD_RD_CFG_B, {4'h1, ~b});
        complete_run();
    end
endmodule : test_hv_indirect_config_regs

// ==== design/hvic_cfg.svh ====
// constants for the high-voltage indirect register block
// assumes a 25 MHz core clock and a word-wide memory-mapped core port
`ifndef HVIC_CFG_SVH
`define HVIC_CFG_SVH
`define HVIC_ADDR_COMMAND 32'hffff0804
`define HVIC_ADDR_DATA 32'hffff080c
`define HVIC_CMD_RD_CFG_A 8'h00
`define HVIC_CMD_RD_CFG_B 8'h01
`define HVIC_CMD_RD_STATUS 8'h02
`define HVIC_CMD_RD_MONITOR 8'h03
`define HVIC_CMD_WR_CFG_A 8'h08
`define HVIC_CMD_WR_CFG_B 8'h09
`define HVIC_CFG_RESET 8'h00
`define HVIC_BIT_THERM_OVR 7
`define HVIC_BIT_OSC_EN 6
`define HVIC_BIT_BSD 5
`define HVIC_BIT_WAKE 4
`define HVIC_BIT_SUPPLY_MON 3
`define HVIC_BIT_LOWV_FLAG 2
`define HVIC_BIT_BUSY 0
`define HVIC_BIT_RD_OK 1
`define HVIC_BIT_WR_OK 2
`define HVIC_MON_BIT_LOWV 3
`define HVIC_SER_CLK_KHZ 2560
`define HVIC_CLK_KHZ 25000
`define HVIC_MAX_LAT_NS 10000
`define HVIC_CLK_NS 40
// link half period rounded down so each bit is no slower than documented
`define HVIC_SER_HALF_CYC ((`HVIC_CLK_KHZ / (2 * `HVIC_SER_CLK_KHZ)) > 0 ? (`HVIC_CLK_KHZ / (2 * `HVIC_SER_CLK_KHZ)) : 1)
`define HVIC_MAX_LAT_CYC (`HVIC_MAX_LAT_NS / `HVIC_CLK_NS)
`define HVIC_FRAME_BITS 16
`endif

// ==== design/hvic_pkg.sv ====
// types for the high-voltage indirect register block
// assumes hvic_cfg.svh is available for constants
package hvic_pkg;
    typedef enum logic [1:0] {
        HVIC_IDLE = 2'b00,
        HVIC_SHIFT = 2'b01,
        HVIC_DONE = 2'b11
    } hvic_state_t;

    // decoded controls for the high-voltage circuits
    typedef struct packed {
        logic thermal_shutdown_en;
        logic precision_osc_en;
        logic lin_pullup_en;
        logic bit_serial_device_mode;
        logic wake_pin_drive;
        logic supply_monitor_en;
        logic supply_irq_en;
        logic lowv_flag_en;
        logic [1:0] lin_mode;
        logic lin_fast;
        logic lin_driver_en;
    } hvic_ctrl_t;

    // core-side memory-mapped access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } hvic_bus_t;
endpackage : hvic_pkg

// ==== design/hvic_top.sv ====
// indirect high-voltage config registers with command port, staging word and serial link
// assumes core strobes are one-cycle and synchronous; die link answers on ser_data_i
//
// Functional notes
// (R1) 12-bit staging register for indirect data
// (R2) bits 11..8 read-only command tag
// (R3) read codes 0..3 select source register
// (R4) codes 08/09 write config A/B
// (R5) low byte is the data byte
// (R6) config A resets zero, indirect only
// (R7) bit7 set disables thermal driver shutdown
// (R8) bit6 enables precision oscillator
// (R9) bit5 removes pull-up, selects bit-serial mode
// (R10) bit4 drives wake pin high; wake held low during thermal shutdown
// (R11) bit3 enables supply monitor with interrupt; interrupt also needs supply_irq_line_en_i
// (R12) bit2 enables low-voltage flag in monitor
// (R13) bits1..0 select LIN driver mode
// (R14) config B resets zero, indirect only
// (R15) software commands only while busy clear
// (R16) serial link at 2.56 MHz, 10 us max; link runs at 3.125 MHz (4-cycle half period)
// (R17) status bits 1,2 report transfer success
// (R18) read completion loads tag and data together
`include "hvic_cfg.svh"
module hvic_top #(
    parameter int CMD_W = 8,
    parameter int DATA_W = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire hvic_pkg::hvic_bus_t bus_i,
    output logic [31:0] rdata_o,
    input wire logic supply_irq_line_en_i,
    input wire logic [7:0] hv_status_reg_i,
    input wire logic [7:0] hv_monitor_reg_i,
    input wire logic thermal_event_i,
    input wire logic ser_data_i,
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic busy_o,
    output hvic_pkg::hvic_ctrl_t ctrl_o
);
    import hvic_pkg::*;

    // refuse widths at elaboration: the frame and the staging word are built for these two
    if (CMD_W != 8 || DATA_W != 12) begin : g_bad_width
        $error("hvic_top supports an 8-bit command and 12-bit data only");
    end

    hvic_state_t state;
    hvic_state_t next_state;
    logic [7:0] hv_circuit_config_a;
    logic [7:0] hv_circuit_config_b;
    logic [11:0] hv_indirect_data;
    logic [7:0] hv_command_port;
    logic rd_ok;
    logic wr_ok;
    logic [4:0] bit_cnt;
    logic [7:0] half_cnt;
    logic [15:0] shreg;
    logic [7:0] rx_byte;
    logic [9:0] lat_cnt;

    // address and command decode
    wire cmd_hit = bus_i.addr == `HVIC_ADDR_COMMAND;
    wire data_hit = bus_i.addr == `HVIC_ADDR_DATA;
    wire cmd_wr = bus_i.wr && cmd_hit && state == HVIC_IDLE; // see (R15)
    wire data_wr = bus_i.wr && data_hit;
    wire is_read = hv_command_port[7:2] == 6'h00; // see (R3)
    wire is_wr_a = hv_command_port == `HVIC_CMD_WR_CFG_A; // see (R4)
    wire is_wr_b = hv_command_port == `HVIC_CMD_WR_CFG_B;
    wire known_cmd = is_read || is_wr_a || is_wr_b;
    wire half_tick = half_cnt == 8'(`HVIC_SER_HALF_CYC - 1); // see (R16)
    wire frame_end = half_tick && ser_clk_o && bit_cnt == 5'(`HVIC_FRAME_BITS - 1);
    // compare at or above so the completion cycle still sees a timeout
    wire timed_out = lat_cnt >= 10'(`HVIC_MAX_LAT_CYC - 1);

    // read source mux on the die side
    logic [7:0] src_byte;
    always_comb begin
        unique case (hv_command_port[1:0])
            2'b00: src_byte = hv_circuit_config_a;
            2'b01: src_byte = hv_circuit_config_b;
            2'b10: src_byte = hv_status_reg_i;
            2'b11: begin
                // low-voltage flag only visible when enabled
                src_byte = hv_monitor_reg_i;
                src_byte[`HVIC_MON_BIT_LOWV] = hv_monitor_reg_i[`HVIC_MON_BIT_LOWV]
                    & hv_circuit_config_a[`HVIC_BIT_LOWV_FLAG]; // see (R12)
            end
        endcase
    end

    // transfer sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            HVIC_IDLE: if (cmd_wr) next_state = HVIC_SHIFT;
            HVIC_SHIFT: if (frame_end || timed_out) next_state = HVIC_DONE;
            HVIC_DONE: next_state = HVIC_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) state <= HVIC_IDLE;
        else state <= next_state;
    end

    // serial link: 8 command bits then 8 data bits, msb first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            half_cnt <= 8'h00;
            bit_cnt <= 5'h00;
            ser_clk_o <= 1'b0;
            ser_data_o <= 1'b0;
            shreg <= 16'h0000;
            rx_byte <= 8'h00;
            lat_cnt <= 10'h000;
        end else if (state == HVIC_IDLE) begin
            half_cnt <= 8'h00;
            bit_cnt <= 5'h00;
            ser_clk_o <= 1'b0;
            ser_data_o <= 1'b0;
            lat_cnt <= 10'h000;
            shreg <= {bus_i.wdata[7:0], hv_indirect_data[7:0]};
        end else if (state == HVIC_SHIFT) begin
            lat_cnt <= lat_cnt + 10'h001; // see (R16)
            half_cnt <= half_tick ? 8'h00 : half_cnt + 8'h01;
            if (half_tick) begin
                ser_clk_o <= ~ser_clk_o;
                if (!ser_clk_o) begin
                    ser_data_o <= shreg[15];
                end else begin
                    shreg <= {shreg[14:0], 1'b0};
                    bit_cnt <= bit_cnt + 5'h01;
                    if (bit_cnt[3]) rx_byte <= {rx_byte[6:0], ser_data_i};
                end
            end
        end else begin
            ser_clk_o <= 1'b0;
        end
    end

    // command register, busy and completion status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hv_command_port <= 8'h00;
            busy_o <= 1'b0;
            rd_ok <= 1'b0;
            wr_ok <= 1'b0;
        end else begin
            if (cmd_wr) begin
                hv_command_port <= bus_i.wdata[7:0];
                busy_o <= 1'b1;
            end else if (state == HVIC_DONE) begin
                busy_o <= 1'b0; // see (R17)
                rd_ok <= is_read && !timed_out;
                wr_ok <= (is_wr_a || is_wr_b) && !timed_out;
            end
        end
    end

    // indirect registers and the staging word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hv_circuit_config_a <= `HVIC_CFG_RESET; // see (R6)
            hv_circuit_config_b <= `HVIC_CFG_RESET; // see (R14)
            hv_indirect_data <= 12'h000;
        end else if (state == HVIC_DONE && known_cmd && !timed_out) begin
            if (is_wr_a) hv_circuit_config_a <= hv_indirect_data[7:0]; // see (R4)
            if (is_wr_b) hv_circuit_config_b <= hv_indirect_data[7:0];
            // tag and byte land in one update, see (R18)
            if (is_read) hv_indirect_data <= {hv_command_port[3:0], src_byte}; // see (R1)
        end else if (data_wr) begin
            // upper nibble ignores writes, see (R2)
            hv_indirect_data[7:0] <= bus_i.wdata[7:0]; // see (R5)
        end
    end

    // read data path
    always_ff @(posedge clk_i) begin
        if (rst_i) rdata_o <= 32'h0000_0000;
        else if (bus_i.rd && data_hit) rdata_o <= {20'h00000, hv_indirect_data};
        else if (bus_i.rd && cmd_hit) rdata_o <= {29'h0, wr_ok, rd_ok, busy_o}; // see (R17)
        else rdata_o <= 32'h0000_0000;
    end

    // decode config A to circuit controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_o <= '0;
        end else begin
            ctrl_o.thermal_shutdown_en <= ~hv_circuit_config_a[`HVIC_BIT_THERM_OVR] & thermal_event_i; // see (R7)
            ctrl_o.precision_osc_en <= hv_circuit_config_a[`HVIC_BIT_OSC_EN]; // see (R8)
            ctrl_o.lin_pullup_en <= ~hv_circuit_config_a[`HVIC_BIT_BSD]; // see (R9)
            ctrl_o.bit_serial_device_mode <= hv_circuit_config_a[`HVIC_BIT_BSD];
            ctrl_o.wake_pin_drive <= hv_circuit_config_a[`HVIC_BIT_WAKE] // see (R10)
                & ~(thermal_event_i & ~hv_circuit_config_a[`HVIC_BIT_THERM_OVR]);
            ctrl_o.supply_monitor_en <= hv_circuit_config_a[`HVIC_BIT_SUPPLY_MON]; // see (R11)
            ctrl_o.supply_irq_en <= hv_circuit_config_a[`HVIC_BIT_SUPPLY_MON] & supply_irq_line_en_i;
            ctrl_o.lowv_flag_en <= hv_circuit_config_a[`HVIC_BIT_LOWV_FLAG]; // see (R12)
            ctrl_o.lin_mode <= hv_circuit_config_a[1:0]; // see (R13)
            ctrl_o.lin_fast <= hv_circuit_config_a[1:0] == 2'b11;
            ctrl_o.lin_driver_en <= hv_circuit_config_a[1];
        end
    end
endmodule : hvic_top
